// *** inc/adc_seq_regs.svh ***
// Timing counts and field positions for the converter sequencer.
// Assumes a 100 MHz system clock; included by the design files.
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

`define SYS_CLK_MHZ 100
`define CONV_TIME_NS 80
`define CONV_CYCLES ((`CONV_TIME_NS * `SYS_CLK_MHZ + 999) / 1000)
`define CODE_MAX 12'hfff
`define REF_SEL_HI 15
`define REF_SEL_LO 14
`define SLOTS_PER_SEQ 8
`define SLOT_COUNT 16

`endif

// *** inc/adc_seq_pkg.sv ***
// Types shared by the converter sequencer and its core handshake.
// Assumes nothing beyond the constants header.
`default_nettype none
package adc_seq_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_START = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_STORE = 4'b1000
  } seq_state_t;
  typedef logic [11:0] code_t;
  typedef logic [3:0] chan_t;
endpackage
`default_nettype wire

// *** inc/adc_core_if.sv ***
// Handshake between the sequencer and the conversion core pacing logic.
// Assumes one clock shared by both sides.
`default_nettype none
interface adc_core_if;
  logic start;
  logic [3:0] chan;
  logic done;
  logic [11:0] code;
  modport seq (output start, output chan, input done, input code);
  modport core (input start, input chan, output done, output code);
endinterface
`default_nettype wire

// *** verilog/adc_core_pacer.sv ***
// Paces conversions on the shared core: forwards the start, clamps the code,
// and enforces the minimum conversion spacing and the sample/hold window.
// Assumes the analog core answers with a done strobe and a raw code.
`default_nettype none
`include "adc_seq_regs.svh"
module adc_core_pacer (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] acq_prescale_i,
  adc_core_if.core seq,
  output logic core_start_o,
  input wire logic core_done_i,
  input wire logic [12:0] core_raw_i
);
  localparam logic [7:0] CONV_CYC = 8'(`CONV_CYCLES);
  logic [7:0] cnt;
  logic busy;
  logic done_seen;
  logic [11:0] code;
  logic done_q;
  // Raw code above full scale saturates to CODE_MAX here rather than being truncated
  wire [11:0] clamp_code = core_raw_i[12] ? `CODE_MAX : core_raw_i[11:0];
  wire window_end = busy && (cnt == 8'h00) && done_seen;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= 8'h00;
      busy <= 1'b0;
      done_seen <= 1'b0;
      code <= 12'h000;
      done_q <= 1'b0;
    end else begin
      done_q <= window_end;
      if (seq.start && !busy) begin
        busy <= 1'b1;
        done_seen <= 1'b0;
        // Acquisition adds acq_prescale_i times 16 cycles to the conversion count in the same counter
        cnt <= CONV_CYC - 8'h01 + {acq_prescale_i, 4'h0};
      end else if (busy) begin
        if (cnt != 8'h00) cnt <= cnt - 8'h01;
        if (core_done_i) begin
          done_seen <= 1'b1;
          code <= clamp_code;
        end
        if (window_end) busy <= 1'b0;
      end
    end
  end
  assign core_start_o = seq.start && !busy;
  assign seq.done = done_q;
  assign seq.code = code;
endmodule
`default_nettype wire

// *** verilog/adc_seq_ctrl.sv ***
// Sequencer control: two 8-slot sequencers or one cascaded 16-slot one,
// triggers, result store, interrupt pacing, clock enable and halt gating.
// Assumes trigger inputs come from other clock domains or pins.
`default_nettype none
`include "adc_seq_regs.svh"
module adc_seq_ctrl #(
  parameter int SLOTS = `SLOT_COUNT
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic analog_clock_enable_i,
  input wire logic halt_i,
  input wire logic cascade_i,
  input wire logic start_stop_i,
  input wire logic int_every_other_i,
  input wire logic [3:0] acq_prescale_i,
  input wire logic [15:0] ref_select_i,
  input wire logic [63:0] slot_chan_i,
  input wire logic [3:0] max_conv_a_i,
  input wire logic [2:0] max_conv_b_i,
  input wire logic sw_start_a_i,
  input wire logic sw_start_b_i,
  input wire logic soc_trigger_a_i,
  input wire logic soc_trigger_b_i,
  input wire logic external_interrupt_two_i,
  input wire logic core_done_i,
  input wire logic [12:0] core_raw_i,
  output logic core_start_o,
  output logic [3:0] core_chan_o,
  output logic analog_active_o,
  output logic [1:0] ext_ref_sel_o,
  output logic [4:0] result_addr_o,
  output logic [11:0] result_data_o,
  output logic [191:0] results_o,
  output logic end_of_sequence_a_o,
  output logic end_of_sequence_b_o,
  output logic irq_a_o,
  output logic irq_b_o,
  output logic busy_a_o,
  output logic busy_b_o
);
  adc_core_if cif ();
  logic [11:0] result_mem [SLOTS];
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [2:0] sync_x;
  logic [2:0] sync_en;
  logic [2:0] sync_halt;
  logic pend_a;
  logic pend_b;
  logic run_a;
  logic run_b;
  logic [3:0] ptr_a;
  logic [2:0] ptr_b;
  logic owner_b;
  logic eos_cnt_a;
  logic eos_cnt_b;
  adc_seq_pkg::seq_state_t state;
  adc_seq_pkg::seq_state_t next_state;
  logic start_q;
  logic [3:0] chan_q;
  logic [3:0] slot_q;

  function automatic logic [3:0] slot_chan(input logic [63:0] v, input logic [3:0] s);
    slot_chan = v[{s, 2'b00} +: 4];
  endfunction

  // Second flop outputs feed logic; third flop used only for edge compare
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      sync_x <= 3'h0;
      sync_en <= 3'h0;
      sync_halt <= 3'h0;
    end else begin
      sync_a <= {sync_a[1:0], soc_trigger_a_i};
      sync_b <= {sync_b[1:0], soc_trigger_b_i};
      sync_x <= {sync_x[1:0], external_interrupt_two_i};
      sync_en <= {sync_en[1:0], analog_clock_enable_i};
      sync_halt <= {sync_halt[1:0], halt_i};
    end
  end

  // Conversion starts and run/pending bookkeeping only advance while enabled and not halted
  wire clk_en = sync_en[1] && !sync_halt[1];
  wire rise_a = sync_a[1] && !sync_a[2];
  wire rise_b = sync_b[1] && !sync_b[2];
  wire rise_x = sync_x[1] && !sync_x[2];
  wire trig_a = sw_start_a_i || rise_a || rise_x;
  // In cascade mode B triggers also start the single sequencer
  wire trig_b = sw_start_b_i || rise_b;
  wire trig_a_all = trig_a || (cascade_i && trig_b);
  wire trig_b_dual = trig_b && !cascade_i;
  wire [3:0] max_a = cascade_i ? max_conv_a_i : {1'b0, max_conv_a_i[2:0]};
  wire last_a = (ptr_a == max_a);
  wire last_b = (ptr_b == max_conv_b_i);
  // A has priority; one converter serves both sides in turn
  wire pick_b = run_b && pend_b && !(run_a && pend_a);
  // Dual mode B slots map to channels 8..15 only
  wire [3:0] slot_sel = pick_b ? {1'b1, ptr_b} : ptr_a;
  wire [3:0] raw_chan = slot_chan(slot_chan_i, slot_sel);
  wire [3:0] sel_chan = cascade_i ? raw_chan : {pick_b, raw_chan[2:0]};
  wire can_go = (run_a && pend_a) || pick_b;
  wire fin = (state == adc_seq_pkg::ST_STORE);
  wire fin_a = fin && !owner_b && last_a;
  wire fin_b = fin && owner_b && last_b;

  always_comb begin
    next_state = state;
    case (state)
      adc_seq_pkg::ST_IDLE: if (can_go && clk_en) next_state = adc_seq_pkg::ST_START;
      adc_seq_pkg::ST_START: next_state = adc_seq_pkg::ST_WAIT;
      adc_seq_pkg::ST_WAIT: if (cif.done) next_state = adc_seq_pkg::ST_STORE;
      adc_seq_pkg::ST_STORE: next_state = adc_seq_pkg::ST_IDLE;
      default: next_state = adc_seq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= adc_seq_pkg::ST_IDLE;
      start_q <= 1'b0;
      chan_q <= 4'h0;
      slot_q <= 4'h0;
      owner_b <= 1'b0;
    end else begin
      state <= next_state;
      start_q <= (state == adc_seq_pkg::ST_IDLE) && can_go && clk_en;
      if (state == adc_seq_pkg::ST_IDLE && can_go && clk_en) begin
        chan_q <= sel_chan;
        slot_q <= slot_sel;
        owner_b <= pick_b;
      end
    end
  end

  // Sequencer run/pending bookkeeping; start/stop waits a trigger per slot
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_a <= 1'b0;
      run_b <= 1'b0;
      pend_a <= 1'b0;
      pend_b <= 1'b0;
      ptr_a <= 4'h0;
      ptr_b <= 3'h0;
    end else if (clk_en) begin
      if (state == adc_seq_pkg::ST_IDLE && can_go) begin
        if (pick_b) pend_b <= 1'b0;
        else pend_a <= 1'b0;
      end
      if (fin && !owner_b) begin
        ptr_a <= last_a ? 4'h0 : ptr_a + 4'h1;
        run_a <= !last_a;
        pend_a <= !last_a && !start_stop_i;
      end
      if (fin && owner_b) begin
        ptr_b <= last_b ? 3'h0 : ptr_b + 3'h1;
        run_b <= !last_b;
        pend_b <= !last_b && !start_stop_i;
      end
      // A trigger arriving with a finish still wins
      if (trig_a_all) begin
        run_a <= 1'b1;
        pend_a <= 1'b1;
      end
      if (trig_b_dual) begin
        run_b <= 1'b1;
        pend_b <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (fin) result_mem[slot_q] <= cif.code;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      eos_cnt_a <= 1'b0;
      eos_cnt_b <= 1'b0;
      irq_a_o <= 1'b0;
      irq_b_o <= 1'b0;
      end_of_sequence_a_o <= 1'b0;
      end_of_sequence_b_o <= 1'b0;
      result_addr_o <= 5'h00;
      result_data_o <= 12'h000;
      busy_a_o <= 1'b0;
      busy_b_o <= 1'b0;
      analog_active_o <= 1'b0;
      ext_ref_sel_o <= 2'h0;
      core_chan_o <= 4'h0;
    end else begin
      end_of_sequence_a_o <= fin_a;
      end_of_sequence_b_o <= fin_b;
      if (fin_a) eos_cnt_a <= !eos_cnt_a;
      if (fin_b) eos_cnt_b <= !eos_cnt_b;
      irq_a_o <= fin_a && (!int_every_other_i || eos_cnt_a);
      irq_b_o <= fin_b && (!int_every_other_i || eos_cnt_b);
      result_addr_o <= fin ? {1'b1, slot_q} : 5'h00;
      if (fin) result_data_o <= cif.code;
      busy_a_o <= run_a;
      busy_b_o <= run_b;
      // Low at reset; on with enable, off again in halt
      analog_active_o <= clk_en;
      ext_ref_sel_o <= ref_select_i[`REF_SEL_HI:`REF_SEL_LO];
      // Loaded with sel_chan, as chan_q is, so the core sees the new channel with its start pulse
      if (state == adc_seq_pkg::ST_IDLE && can_go && clk_en) core_chan_o <= sel_chan;
    end
  end

  assign cif.start = start_q;
  assign cif.chan = chan_q;

  adc_core_pacer u_pacer (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .acq_prescale_i(acq_prescale_i),
    .seq(cif),
    .core_start_o(core_start_o),
    .core_done_i(core_done_i),
    .core_raw_i(core_raw_i)
  );

  // Flat copy of stored codes; slot memory is not reset
  always_comb begin
    for (int i = 0; i < SLOTS; i++) results_o[i*12 +: 12] = result_mem[i];
  end
endmodule
`default_nettype wire

// *** dv/adc_seq_ctrl_monitor.sv ***
// Port-level assertions for the converter sequencer.
// Assumes one clock and the asynchronous active-low reset.
`default_nettype none
module adc_seq_ctrl_checker #(
  parameter int SLOTS = 16
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic analog_clock_enable_i,
  input wire logic halt_i,
  input wire logic cascade_i,
  input wire logic [15:0] ref_select_i,
  input wire logic core_start_o,
  input wire logic [3:0] core_chan_o,
  input wire logic analog_active_o,
  input wire logic [1:0] ext_ref_sel_o,
  input wire logic [4:0] result_addr_o,
  input wire logic end_of_sequence_a_o,
  input wire logic end_of_sequence_b_o,
  input wire logic irq_b_o,
  input wire logic busy_a_o,
  input wire logic busy_b_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // Enable and halt pass a synchroniser, so the gate is judged after it settles
  wire logic off = halt_i || !analog_clock_enable_i;
  ref_sel_a: assert property ($past(nrst_i) |-> ext_ref_sel_o == $past(ref_select_i[15:14]))
    else $error("reference select not forwarded");
  start_gate_a: assert property (off [*6] |-> !core_start_o)
    else $error("conversion started while gated");
  analog_off_a: assert property (off [*4] |-> !analog_active_o)
    else $error("analog part active while gated");
  analog_on_a: assert property (!off [*4] |-> analog_active_o)
    else $error("analog part idle while enabled");
  core_gap_a: assert property (core_start_o |=> !core_start_o [*7])
    else $error("conversions closer than one slot");
  chan_hold_a: assert property (core_start_o |=> $stable(core_chan_o) [*3])
    else $error("channel moved during conversion");
  own_chan_a: assert property (core_start_o && !cascade_i && busy_a_o |-> !core_chan_o[3])
    else $error("first sequencer left its channels");
  side_chan_b_a: assert property (core_start_o && !cascade_i && !busy_a_o && busy_b_o
    |-> core_chan_o[3])
    else $error("second sequencer left its channels");
  // Sequence end and its last store leave the same register stage together
  eos_store_a: assert property (end_of_sequence_a_o |-> result_addr_o[4])
    else $error("sequence end without a store");
  eos_b_store_a: assert property (end_of_sequence_b_o |-> result_addr_o[4])
    else $error("second sequence end without a store");
  irq_pace_b_a: assert property (irq_b_o |-> end_of_sequence_b_o)
    else $error("second interrupt without a sequence end");
  cover property (core_start_o && cascade_i);
  cover property (core_start_o && !cascade_i && busy_b_o);
  cover property (end_of_sequence_a_o);
endmodule
bind adc_seq_ctrl adc_seq_ctrl_checker #(.SLOTS(SLOTS)) chk (.sys_clk_i, .nrst_i,
  .analog_clock_enable_i, .halt_i, .cascade_i, .ref_select_i, .core_start_o, .core_chan_o,
  .analog_active_o, .ext_ref_sel_o, .result_addr_o, .end_of_sequence_a_o, .end_of_sequence_b_o,
  .irq_b_o, .busy_a_o, .busy_b_o);
`default_nettype wire

// *** dv/adc_core_model.sv ***
// Behavioural conversion core: answers each start after a chosen latency.
// Assumes starts are single-cycle pulses on the system clock.
`default_nettype none
module adc_core_model (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic [3:0] chan_i,
  input wire logic [3:0] lat_i,
  input wire logic over_i,
  output logic done_o,
  output logic [12:0] raw_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt;
  logic [3:0] ch;
  wire logic fin = cnt == 5'h01;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= 5'h00;
      ch <= 4'h0;
      done_o <= 1'b0;
      raw_o <= 13'h0000;
    end else begin
      done_o <= fin;
      // Code is only valid with done; otherwise it toggles so stale reads show
      raw_o <= fin ? (over_i ? 13'h1000 : {1'b0, ch, 8'h5a}) : ~raw_o;
      if (start_i) begin
        cnt <= {1'b0, lat_i} + 5'h02;
        ch <= chan_i;
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

// *** dv/adc_seq_ctrl_bench.sv ***
// Self-checking bench for the converter sequencer with a core model.
// Assumes the checker is bound from its own file.
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module adc_seq_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0, nrst_i = 1'b0, analog_clock_enable_i = 1'b0, halt_i = 1'b0;
  logic cascade_i = 1'b1, start_stop_i = 1'b0, int_every_other_i = 1'b0, over = 1'b0;
  logic sw_start_a_i = 1'b0, sw_start_b_i = 1'b0, soc_trigger_a_i = 1'b0;
  logic soc_trigger_b_i = 1'b0, external_interrupt_two_i = 1'b0;
  logic [3:0] acq_prescale_i = 4'h0, max_conv_a_i = 4'h0, lat = 4'h0;
  logic [2:0] max_conv_b_i = 3'h0;
  logic [15:0] ref_select_i = 16'h0000;
  logic [63:0] slot_chan_i = 64'h0;
  logic core_done_i, core_start_o, analog_active_o, end_of_sequence_a_o, end_of_sequence_b_o;
  logic irq_a_o, irq_b_o, busy_a_o, busy_b_o;
  logic [12:0] core_raw_i;
  logic [3:0] core_chan_o;
  logic [1:0] ext_ref_sel_o;
  logic [4:0] result_addr_o;
  logic [11:0] result_data_o;
  logic [16:0] exp_q[$];
  logic [31:0] seed = 32'he575;
  int miscompares = 0, cmp_count = 0, irqs = 0, i0;
  always #5 sys_clk_i = ~sys_clk_i;
  adc_seq_ctrl #(.SLOTS(16)) uut (.sys_clk_i, .nrst_i, .analog_clock_enable_i, .halt_i,
    .cascade_i, .start_stop_i, .int_every_other_i, .acq_prescale_i, .ref_select_i, .slot_chan_i,
    .max_conv_a_i, .max_conv_b_i, .sw_start_a_i, .sw_start_b_i, .soc_trigger_a_i,
    .soc_trigger_b_i, .external_interrupt_two_i, .core_done_i, .core_raw_i, .core_start_o,
    .core_chan_o, .analog_active_o, .ext_ref_sel_o, .result_addr_o, .result_data_o,
    .results_o(), .end_of_sequence_a_o, .end_of_sequence_b_o, .irq_a_o, .irq_b_o, .busy_a_o,
    .busy_b_o);
  adc_core_model core (.sys_clk_i, .nrst_i, .start_i(core_start_o), .chan_i(core_chan_o),
    .lat_i(lat), .over_i(over), .done_o(core_done_i), .raw_o(core_raw_i));
  always @(posedge sys_clk_i) begin
    irqs <= irqs + int'(irq_a_o);
    if (result_addr_o[4] === 1'b1) begin
      if (exp_q.size() == 0)
        `CHK({result_addr_o, result_data_o}, 17'h0)
      else
        `CHK({result_addr_o, result_data_o}, exp_q.pop_front())
    end
  end
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic close_out();
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic fire(ref logic p);
    p = 1'b1;
    cyc(3);
    p = 1'b0;
  endtask
  task automatic slot(int s, logic [3:0] c);
    slot_chan_i[4*s+:4] = c;
    exp_q.push_back({1'b1, 4'(s), over ? 12'hfff : {c, 8'h5a}});
  endtask
  task automatic drain();
    int n;
    n = 0;
    // In start/stop mode a sequence stays busy between triggers
    while ((exp_q.size() != 0 || ((busy_a_o !== 1'b0 || busy_b_o !== 1'b0) && !start_stop_i))
      && n < 3000) begin
      cyc(1);
      n++;
    end
    if (n == 3000) begin
      miscompares++;
      close_out();
    end
    cyc(20);
  endtask
  initial begin
    cyc(6);
    nrst_i = 1'b1;
    fire(sw_start_a_i);
    drain();
    seed = lfsr(seed);
    ref_select_i = seed[15:0];
    analog_clock_enable_i = 1'b1;
    // Settling wait shortened; the real part needs far longer
    cyc(50);
    max_conv_a_i = 4'hf;
    lat = seed[5:2];
    for (int s = 0; s < 16; s++) begin
      seed = lfsr(seed);
      slot(s, s == 1 ? slot_chan_i[3:0] : seed[3:0]);
    end
    fire(sw_start_a_i);
    drain();
    cascade_i = 1'b0;
    max_conv_a_i = 4'h2;
    max_conv_b_i = 3'h1;
    over = 1'b1;
    acq_prescale_i = 4'h1;
    lat = 4'h0;
    for (int s = 0; s < 3; s++) slot(s, {1'b0, 3'(s + 5)});
    for (int s = 8; s < 10; s++) slot(s, {1'b1, 3'(s)});
    soc_trigger_a_i = 1'b1;
    soc_trigger_b_i = 1'b1;
    cyc(3);
    soc_trigger_a_i = 1'b0;
    soc_trigger_b_i = 1'b0;
    drain();
    over = 1'b0;
    acq_prescale_i = 4'h0;
    cascade_i = 1'b1;
    max_conv_a_i = 4'h0;
    for (int e = 0; e < 2; e++) begin
      int_every_other_i = 1'(e);
      i0 = irqs;
      slot(0, 4'(e + 9));
      fire(external_interrupt_two_i);
      drain();
      slot(0, 4'(e + 3));
      fire(sw_start_a_i);
      drain();
      `CHK(irqs - i0, 2 - e)
    end
    start_stop_i = 1'b1;
    max_conv_a_i = 4'h1;
    slot(0, 4'hc);
    fire(sw_start_a_i);
    drain();
    `CHK(busy_a_o, 1'b1)
    slot(1, 4'hc);
    fire(sw_start_a_i);
    drain();
    `CHK(busy_a_o, 1'b0)
    start_stop_i = 1'b0;
    halt_i = 1'b1;
    cyc(6);
    fire(sw_start_a_i);
    drain();
    halt_i = 1'b0;
    cyc(10);
    close_out();
  end
endmodule
`default_nettype wire
